// ==== hw/kee_encoder.sv ====
// Keypad event encoder: turns key matrix levels into 16-bit key event words
// for the serial graphic link, with an APB register slave and one interrupt.
// Assumes key levels and switch inputs are synchronous and already debounced.
`timescale 1ns/100ps

module kee_encoder #(
	parameter int CASE_POS = kee_pkg::CASE_POS_DEF,
	parameter int CTRL_POS = kee_pkg::CTRL_POS_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Key matrix levels, index line * 8 + column
	input wire logic [kee_pkg::KEY_COUNT-1:0] key_state,
	// Orientation switches
	input wire logic orient_sw8,
	input wire logic orient_sw9,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event stream to the serial graphic link
	output logic [kee_pkg::EVT_W-1:0] evt_word,
	output logic evt_valid,
	input wire logic evt_ready,
	// Display rotation and interrupt
	output logic [1:0] display_rotation,
	output logic irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum logic {KEE_SCAN, KEE_SEND} kee_state_t;

	kee_state_t state_reg;
	kee_state_t state_next;
	logic [kee_pkg::KEY_COUNT-1:0] last_reg;
	logic [kee_pkg::KEY_COUNT-1:0] last_next;
	logic [7:0] user_tab [kee_pkg::KEY_COUNT];
	logic [1:0] mode_reg;
	logic [kee_pkg::EVT_W-1:0] evt_reg;
	logic [kee_pkg::EVT_W-1:0] evt_next;
	logic [kee_pkg::ST_W-1:0] status_reg;
	logic [kee_pkg::ST_W-1:0] status_next;
	logic [kee_pkg::ST_W-1:0] mask_reg;
	logic [1:0] rotate_reg;
	logic [31:0] rdata_reg;
	logic err_reg;

	logic found;
	logic [kee_pkg::KEY_IDX_W-1:0] found_idx;
	logic take;
	logic is_release;
	logic case_held;
	logic ctrl_held;
	logic [7:0] pos_code;
	logic [7:0] user_code;
	logic [7:0] predef_code;
	logic [7:0] key_code;
	logic setup_ph;
	logic wr_en;
	logic hit_mapped;
	logic wr_mode;
	logic wr_table;
	logic wr_status;
	logic wr_mask;
	logic [kee_pkg::KEY_IDX_W-1:0] tab_idx;
	logic [31:0] rd_mux;
	logic [kee_pkg::ST_W-1:0] ev_set;

	// ****************************************************************
	// Change detection
	// ****************************************************************

	// One changed key is taken at a time, so two changes never merge.
	kee_change_finder #(
		.N(kee_pkg::KEY_COUNT),
		.IW(kee_pkg::KEY_IDX_W)
	) u_finder (
		.now_state(key_state),
		.last_state(last_reg),
		.found(found),
		.idx(found_idx)
	);

	// Event formation terms.
	assign take = (state_reg == KEE_SCAN) && found;
	assign is_release = last_reg[found_idx];
	assign case_held = key_state[CASE_POS] && (found_idx != kee_pkg::KEY_IDX_W'(CASE_POS));
	assign ctrl_held = key_state[CTRL_POS] && (found_idx != kee_pkg::KEY_IDX_W'(CTRL_POS));
	assign pos_code = {1'b0, found_idx[5:3], 1'b0, found_idx[2:0]};
	assign user_code = user_tab[found_idx];
	assign predef_code = kee_pkg::kee_predef_code(found_idx);
	assign key_code = (mode_reg == kee_pkg::KEE_MODE_USER) ? user_code :
		(mode_reg == kee_pkg::KEE_MODE_PREDEF) ? predef_code : pos_code;

	// Word layout: release flag, zero reserved bits, modifiers, code.
	assign evt_next = {is_release, 5'h00, case_held, ctrl_held, key_code};

	// Sticky event sources.
	assign ev_set[kee_pkg::ST_HIT_BIT] = take && !is_release;
	assign ev_set[kee_pkg::ST_REL_BIT] = take && is_release;

	// Next state of the sender.
	always_comb begin
		state_next = state_reg;
		last_next = last_reg;
		case (state_reg)
			KEE_SCAN: begin
				if (found) begin
					state_next = KEE_SEND;
					last_next[found_idx] = key_state[found_idx];
				end
			end
			KEE_SEND: begin
				if (evt_ready) begin
					state_next = KEE_SCAN;
				end
			end
			default: state_next = KEE_SCAN;
		endcase
	end

	// Sender registers; the word holds until the link takes it.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= KEE_SCAN;
			last_reg <= '0;
			evt_reg <= '0;
		end else begin
			state_reg <= state_next;
			last_reg <= last_next;
			if (take) begin
				evt_reg <= evt_next;
			end
		end
	end

	assign evt_valid = (state_reg == KEE_SEND);
	assign evt_word = evt_reg;

	// ****************************************************************
	// Orientation
	// ****************************************************************

	// Switch 9 is the high bit, switch 8 the low bit.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rotate_reg <= kee_pkg::ROTATE_RESET;
		end else begin
			rotate_reg <= {orient_sw9, orient_sw8};
		end
	end

	assign display_rotation = rotate_reg;

	// ****************************************************************
	// APB slave
	// ****************************************************************

	// Address decode and write strobes.
	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign hit_mapped = (paddr == kee_pkg::OFF_MODE) || (paddr == kee_pkg::OFF_TABLE) ||
		(paddr == kee_pkg::OFF_LAST) || (paddr == kee_pkg::OFF_STATUS) ||
		(paddr == kee_pkg::OFF_MASK) || (paddr == kee_pkg::OFF_ROTATE);
	assign wr_mode = wr_en && (paddr == kee_pkg::OFF_MODE);
	assign wr_table = wr_en && (paddr == kee_pkg::OFF_TABLE);
	assign wr_status = wr_en && (paddr == kee_pkg::OFF_STATUS);
	assign wr_mask = wr_en && (paddr == kee_pkg::OFF_MASK);
	assign tab_idx = pwdata[kee_pkg::TAB_IDX_LSB +: kee_pkg::KEY_IDX_W];

	// Read selection; the table entry register reads as zero.
	assign rd_mux = (paddr == kee_pkg::OFF_MODE) ? {30'h0, mode_reg} :
		(paddr == kee_pkg::OFF_LAST) ? {16'h0, evt_reg} :
		(paddr == kee_pkg::OFF_STATUS) ? {30'h0, status_reg} :
		(paddr == kee_pkg::OFF_MASK) ? {30'h0, mask_reg} :
		(paddr == kee_pkg::OFF_ROTATE) ? {30'h0, rotate_reg} : 32'h0;

	// Read data and error are captured in the setup cycle.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= 32'h0;
			err_reg <= 1'b0;
		end else if (setup_ph) begin
			rdata_reg <= pwrite ? 32'h0 : rd_mux;
			err_reg <= !hit_mapped;
		end
	end

	assign prdata = rdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_reg;

	// Code source; the host loads entries first, then picks the mode.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_reg <= kee_pkg::MODE_RESET;
			mask_reg <= kee_pkg::MASK_RESET;
		end else begin
			if (wr_mode && (pwdata[1:0] != 2'h3)) begin
				mode_reg <= pwdata[1:0];
			end
			if (wr_mask) begin
				mask_reg <= pwdata[kee_pkg::ST_W-1:0];
			end
		end
	end

	// User key table storage, no reset needed as mode gates its use.
	always_ff @(posedge mclk) begin
		if (wr_table) begin
			user_tab[tab_idx] <= pwdata[kee_pkg::TAB_CODE_LSB +: 8];
		end
	end

	// ****************************************************************
	// Interrupt
	// ****************************************************************

	// A new event in the clearing cycle keeps its bit set.
	assign status_next = (status_reg & ~(wr_status ? pwdata[kee_pkg::ST_W-1:0] : 2'h0)) | ev_set;

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	assign irq = |(status_reg & mask_reg);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	hit_clear_a: assert property (take && !is_release |=> evt_valid && !evt_word[15])
		else $error("hit event has release flag set");

	release_set_a: assert property (take && is_release |=> evt_valid && evt_word[15])
		else $error("release event lacks release flag");

	pair_track_a: assert property (take |=> last_reg[$past(found_idx)] == $past(key_state[found_idx]))
		else $error("reported key level not recorded");

	position_code_a: assert property (take && mode_reg == 2'h0 |=>
		evt_word[7:0] == {1'b0, $past(found_idx[5:3]), 1'b0, $past(found_idx[2:0])})
		else $error("position code wrong");

	user_code_a: assert property (take && mode_reg == 2'h1 |=> evt_word[7:0] == $past(user_code))
		else $error("user table code not applied");

	predef_digit_a: assert property (take && mode_reg == 2'h2 && found_idx == 6'h00 |=>
		evt_word[7:0] == 8'h31)
		else $error("built-in code for digit one wrong");

	case_mod_a: assert property (take && key_state[CASE_POS] && found_idx != 6'(CASE_POS) |=>
		evt_word[9])
		else $error("case modifier bit missing");

	ctrl_set_a: assert property (take && key_state[CTRL_POS] && found_idx != 6'(CTRL_POS) |=>
		evt_word[8])
		else $error("control modifier bit missing");

	ctrl_mod_a: assert property (take && !key_state[CTRL_POS] |=> !evt_word[8])
		else $error("control bit set without control key");

	reserved_zero_a: assert property (evt_valid |-> evt_word[14:10] == 5'h00)
		else $error("reserved event bits not zero");

	word_hold_a: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_word))
		else $error("event word changed before accepted");

	rotation_follow_a: assert property (##1 display_rotation == {$past(orient_sw9), $past(orient_sw8)})
		else $error("rotation does not follow switches");

endmodule : kee_encoder

// ==== include/kee_pkg.sv ====
// Constants shared by the keypad event encoder: register map, field layout,
// reset values, code table modes and the built-in key table.
// Assumes an 8 x 8 key matrix indexed as line * 8 + column.
package kee_pkg;

	// ****************************************************************
	// Matrix geometry
	// ****************************************************************
	localparam int KEY_LINES = 8;
	localparam int KEY_COLS = 8;
	localparam int KEY_COUNT = KEY_LINES * KEY_COLS;
	localparam int KEY_IDX_W = 6;

	// ****************************************************************
	// Event word layout
	// ****************************************************************
	localparam int EVT_W = 16;
	localparam int EVT_RELEASE_BIT = 15;
	localparam int EVT_CTRL_BIT = 8;
	localparam int EVT_CASE_BIT = 9;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_TABLE = 8'h04;
	localparam logic [7:0] OFF_LAST = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_ROTATE = 8'h14;

	// Fields of the table entry register.
	localparam int TAB_IDX_LSB = 8;
	localparam int TAB_CODE_LSB = 0;

	// Sticky status bits.
	localparam int ST_HIT_BIT = 0;
	localparam int ST_REL_BIT = 1;
	localparam int ST_W = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] ROTATE_RESET = 2'h0;
	localparam logic [ST_W-1:0] MASK_RESET = 2'h0;

	// Default modifier key positions in the matrix.
	localparam int CASE_POS_DEF = 16;
	localparam int CTRL_POS_DEF = 19;

	// Source of the key code.
	typedef enum logic [1:0] {
		KEE_MODE_POSITION = 2'h0,
		KEE_MODE_USER = 2'h1,
		KEE_MODE_PREDEF = 2'h2
	} kee_mode_t;

	// Built-in key table; positions without a key give code zero.
	function automatic logic [7:0] kee_predef_code(input logic [KEY_IDX_W-1:0] pos);
		logic [7:0] code;
		code = 8'h00;
		case (pos)
			6'h00: code = 8'h31;
			6'h01: code = 8'h32;
			6'h02: code = 8'h33;
			6'h03: code = 8'h34;
			6'h04: code = 8'h35;
			6'h05: code = 8'h36;
			6'h06: code = 8'h37;
			6'h07: code = 8'h38;
			6'h08: code = 8'h39;
			6'h09: code = 8'h30;
			6'h0a: code = 8'h2d;
			6'h0b: code = 8'h2e;
			6'h0c: code = 8'h1b;
			6'h0d: code = 8'h7f;
			6'h0e: code = 8'h0d;
			6'h10: code = 8'hf1;
			6'h11: code = 8'hf2;
			6'h12: code = 8'hf3;
			6'h13: code = 8'hf4;
			default: code = 8'h00;
		endcase
		return code;
	endfunction : kee_predef_code

endpackage : kee_pkg

// ==== hw/kee_change_finder.sv ====
// Finds the lowest numbered key whose level differs from its last reported level.
// Assumes both vectors are synchronous to the same clock.
`timescale 1ns/100ps

module kee_change_finder #(
	parameter int N = 64,
	parameter int IW = 6
) (
	// Key levels
	input wire logic [N-1:0] now_state,
	input wire logic [N-1:0] last_state,
	// Result
	output logic found,
	output logic [IW-1:0] idx
);

	logic [N-1:0] diff;

	// Keys whose level has changed.
	assign diff = now_state ^ last_state;

	// Priority search from the top so the lowest index wins.
	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (diff[i]) begin
				found = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule : kee_change_finder

// ==== tb/kee_link_model.sv ====
// Link partner model: takes key event words from the encoder.
// Assumes it shares the encoder clock; stall lets the bench slow the link.
`timescale 1ns/100ps

module kee_link_model (
	// Clock
	input wire logic mclk,
	// Event stream
	input wire logic [15:0] evt_word,
	input wire logic evt_valid,
	output logic evt_ready,
	// Bench control and capture
	input wire logic stall,
	output logic [15:0] got_word,
	output int got_count
);
	// Ready drops while the bench asks for a stall.
	assign evt_ready = ~stall;

	// Each word taken at a handshake edge is kept and counted.
	always_ff @(posedge mclk) begin
		if (evt_valid && evt_ready) begin
			got_word <= evt_word;
			got_count <= got_count + 1;
		end
	end
endmodule : kee_link_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the keypad event encoder.
// Assumes the encoder, its package and the link model are compiled first.
`timescale 1ns/100ps

module tb_top;
	logic mclk, rst, orient_sw8, orient_sw9, psel, penable, pwrite, stall, err;
	logic pready, pslverr, evt_valid, evt_ready, irq;
	logic [63:0] key_state;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] evt_word, got_word;
	logic [1:0] display_rotation;
	logic [7:0] tc [19] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h30,
		8'h2d, 8'h2e, 8'h1b, 8'h7f, 8'h0d, 8'hf1, 8'hf2, 8'hf3, 8'hf4};
	int got_count, n_fail, check_count;

	kee_encoder dut (.mclk(mclk), .rst(rst), .key_state(key_state), .orient_sw8(orient_sw8),
		.orient_sw9(orient_sw9), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_word(evt_word),
		.evt_valid(evt_valid), .evt_ready(evt_ready), .display_rotation(display_rotation), .irq(irq));
	kee_link_model link (.mclk(mclk), .evt_word(evt_word), .evt_valid(evt_valid),
		.evt_ready(evt_ready), .stall(stall), .got_word(got_word), .got_count(got_count));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task print_verdict;
		if (n_fail == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// One APB transfer; the request holds until pready is seen, then one idle edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	// Moves one key and compares the next word the link accepts.
	task key(input int idx, input logic lvl, input logic [15:0] exp);
		int n;
		n = got_count;
		key_state[idx] <= lvl;
		while (got_count == n) begin
			@(posedge mclk);
		end
		check(got_word, exp);
	endtask : key

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_rotation;
		check(evt_valid, 1'b0);
		for (int c = 0; c < 4; c++) begin
			orient_sw9 <= c[1];
			orient_sw8 <= c[0];
			repeat (2) @(posedge mclk);
			check(display_rotation, c[1:0]);
			apb(1'b0, kee_pkg::OFF_ROTATE, 32'h0);
			check(rd, {30'h0, c[1:0]});
		end
	endtask : t_rotation

	// Position codes, a stalled link and release order.
	task t_position;
		key(21, 1'b1, 16'h0025);
		stall <= 1'b1;
		key_state[3] <= 1'b1;
		repeat (4) @(posedge mclk);
		check(evt_valid, 1'b1);
		check(evt_word, 16'h0003);
		stall <= 1'b0;
		repeat (2) @(posedge mclk);
		check(got_word, 16'h0003);
		key(3, 1'b0, 16'h8003);
		key(21, 1'b0, 16'h8025);
	endtask : t_position

	// Every built-in code, hit and release.
	task t_predef;
		apb(1'b1, kee_pkg::OFF_MODE, 32'h2);
		for (int i = 0; i < 19; i++) begin
			key((i < 15) ? i : i + 1, 1'b1, {8'h00, tc[i]});
			key((i < 15) ? i : i + 1, 1'b0, {8'h80, tc[i]});
		end
	endtask : t_predef

	task t_modifier;
		key(16, 1'b1, 16'h00f1);
		key(0, 1'b1, 16'h0231);
		key(0, 1'b0, 16'h8231);
		key(19, 1'b1, 16'h02f4);
		key(1, 1'b1, 16'h0332);
		key(1, 1'b0, 16'h8332);
		key(19, 1'b0, 16'h82f4);
		key(16, 1'b0, 16'h80f1);
	endtask : t_modifier

	task t_user;
		apb(1'b1, kee_pkg::OFF_TABLE, 32'h0000155a);
		apb(1'b1, kee_pkg::OFF_MODE, 32'h1);
		key(21, 1'b1, 16'h005a);
		key(21, 1'b0, 16'h805a);
	endtask : t_user

	// Interrupt raise, mask, clear; last word; unmapped address.
	task t_irq;
		apb(1'b1, kee_pkg::OFF_MODE, 32'h0);
		apb(1'b1, kee_pkg::OFF_MODE, 32'h3);
		apb(1'b0, kee_pkg::OFF_MODE, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, kee_pkg::OFF_STATUS, 32'h3);
		apb(1'b1, kee_pkg::OFF_MASK, 32'h1);
		check(irq, 1'b0);
		key(5, 1'b1, 16'h0005);
		check(irq, 1'b1);
		apb(1'b0, kee_pkg::OFF_STATUS, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, kee_pkg::OFF_STATUS, 32'h1);
		check(irq, 1'b0);
		key(5, 1'b0, 16'h8005);
		check(irq, 1'b0);
		apb(1'b0, kee_pkg::OFF_LAST, 32'h0);
		check(rd, 32'h8005);
		apb(1'b0, 8'h40, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
	endtask : t_irq

	// Clock.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Reset, then the scenarios in turn.
	initial begin
		{rst, orient_sw8, orient_sw9, psel, penable, pwrite, stall} = 7'h40;
		key_state = 64'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_rotation();
		t_position();
		t_predef();
		t_modifier();
		t_user();
		t_irq();
		print_verdict();
	end

	// Watchdog.
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end
endmodule : tb_top
